// ===== bcs_sequencer.sv
module bcs_sequencer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  input bcs_pkg::bcs_req_type req_in,
  output logic req_ready_out,
  input wire logic ready_in,
  input wire logic hold_in,
  output logic hold_ack_out,
  input wire logic [7:0] low_address_data_lines_in,
  output logic [7:0] low_address_data_lines_out,
  output logic low_address_data_lines_oe_out,
  output logic [7:0] high_address_lines_out,
  output logic high_address_lines_oe_out,
  output logic io_select_out,
  output logic io_select_oe_out,
  output logic cycle_status_1_out,
  output logic cycle_status_0_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic read_write_oe_out,
  output logic interrupt_ack_strobe_n_out,
  output logic address_latch_out,
  output logic [7:0] read_data_out,
  output logic cycle_done_out
);

  bcs_pkg::bcs_core_type q;
  bcs_pkg::bcs_core_type d;
  logic hold_sync;
  logic finish;
  logic take;

  bcs_sync hold_sync_inst (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .level_in(hold_in),
    .level_out(hold_sync)
  );

  function automatic logic [2:0] status_of(input bcs_pkg::bcs_kind_type k);
    unique case (k)
      bcs_pkg::kind_fetch: status_of = bcs_pkg::STAT_FETCH;
      bcs_pkg::kind_mem_rd: status_of = bcs_pkg::STAT_MEM_RD;
      bcs_pkg::kind_mem_wr: status_of = bcs_pkg::STAT_MEM_WR;
      bcs_pkg::kind_io_rd: status_of = bcs_pkg::STAT_IO_RD;
      bcs_pkg::kind_io_wr: status_of = bcs_pkg::STAT_IO_WR;
      bcs_pkg::kind_int_ack: status_of = bcs_pkg::STAT_INT_ACK;
      bcs_pkg::kind_idle_add: status_of = bcs_pkg::STAT_IDLE_ADD;
      bcs_pkg::kind_idle_rst: status_of = bcs_pkg::STAT_IDLE_RST;
      default: status_of = bcs_pkg::STAT_HALT;
    endcase
  endfunction : status_of

  function automatic logic [2:0] strobes_of(input bcs_pkg::bcs_kind_type k);
    unique case (k)
      bcs_pkg::kind_fetch,
      bcs_pkg::kind_mem_rd,
      bcs_pkg::kind_io_rd: strobes_of = bcs_pkg::STRB_READ;
      bcs_pkg::kind_mem_wr,
      bcs_pkg::kind_io_wr: strobes_of = bcs_pkg::STRB_WRITE;
      bcs_pkg::kind_int_ack: strobes_of = bcs_pkg::STRB_ACK;
      default: strobes_of = bcs_pkg::STRB_NONE;
    endcase
  endfunction : strobes_of

  function automatic logic is_io(input bcs_pkg::bcs_kind_type k);
    is_io = (k == bcs_pkg::kind_io_rd) || (k == bcs_pkg::kind_io_wr);
  endfunction : is_io

  function automatic logic is_write(input bcs_pkg::bcs_kind_type k);
    is_write = (k == bcs_pkg::kind_mem_wr) || (k == bcs_pkg::kind_io_wr);
  endfunction : is_write

  // Pins are decoded from the next state and registered, so every bus
  // output changes on the same edge as the state it belongs to.
  function automatic bcs_pkg::bcs_pins_type drive(
    input bcs_pkg::bcs_state_type st,
    input bcs_pkg::bcs_req_type req,
    input bcs_pkg::bcs_pins_type prev
  );
    bcs_pkg::bcs_pins_type p;
    p = prev;
    p.ale = 1'b0;
    p.low_oe = 1'b0;
    p.rd_n = 1'b1;
    p.wr_n = 1'b1;
    p.interrupt_ack_strobe_n_n = 1'b1;
    unique case (st)
      bcs_pkg::st_t1:
      begin
        {p.io_m, p.s1, p.s0} = status_of(req.kind);
        p.io_m_oe = 1'b1;
        p.rw_oe = 1'b1;
        p.ale = !req.no_ale;
        p.high_addr = is_io(req.kind) ? req.addr[7:0] : req.addr[15:8];
        p.high_oe = 1'b1;
        p.low_out = req.addr[7:0];
        p.low_oe = 1'b1;
      end
      bcs_pkg::st_t2, bcs_pkg::st_wait, bcs_pkg::st_t3:
      begin
        {p.rd_n, p.wr_n, p.interrupt_ack_strobe_n_n} = strobes_of(req.kind);
        p.low_out = req.wdata;
        p.low_oe = is_write(req.kind);
      end
      bcs_pkg::st_t4, bcs_pkg::st_t5, bcs_pkg::st_t6:
      begin
        // High address keeps its last value; users must treat it as junk.
        p.s1 = 1'b1;
        p.s0 = 1'b1;
        p.io_m = (req.kind == bcs_pkg::kind_int_ack);
      end
      bcs_pkg::st_halt:
      begin
        p.s1 = 1'b0;
        p.s0 = 1'b0;
        p.io_m_oe = 1'b0;
        p.rw_oe = 1'b0;
        p.high_oe = 1'b0;
      end
      bcs_pkg::st_reset, bcs_pkg::st_hold:
      begin
        p.io_m_oe = 1'b0;
        p.rw_oe = 1'b0;
        p.high_oe = 1'b0;
      end
    endcase
    return p;
  endfunction : drive

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    finish = 1'b0;
    take = 1'b0;
    unique case (q.st)
      bcs_pkg::st_reset: finish = 1'b1;
      bcs_pkg::st_t1: d.st = bcs_pkg::st_t2;
      bcs_pkg::st_t2, bcs_pkg::st_wait:
        d.st = ready_in ? bcs_pkg::st_t3 : bcs_pkg::st_wait;
      bcs_pkg::st_t3:
      begin
        d.done = 1'b1;
        if (strobes_of(q.req.kind) == bcs_pkg::STRB_READ
            || q.req.kind == bcs_pkg::kind_int_ack)
          d.rdata = low_address_data_lines_in;
        // Acknowledge cycles run the late states too, with select held high.
        if (q.req.kind == bcs_pkg::kind_fetch
            || q.req.kind == bcs_pkg::kind_int_ack)
          d.st = bcs_pkg::st_t4;
        else
          finish = 1'b1;
      end
      bcs_pkg::st_t4:
        if (q.req.long_fetch)
          d.st = bcs_pkg::st_t5;
        else
          finish = 1'b1;
      bcs_pkg::st_t5: d.st = bcs_pkg::st_t6;
      bcs_pkg::st_t6: finish = 1'b1;
      bcs_pkg::st_halt:
        finish = hold_sync
                 || (req_valid_in && req_in.kind != bcs_pkg::kind_halt);
      bcs_pkg::st_hold:
        if (!hold_sync && q.req.kind == bcs_pkg::kind_halt)
          d.st = bcs_pkg::st_halt;
        else
          finish = !hold_sync;
    endcase
    if (finish)
    begin
      // Hold is only honoured between cycles, so no transfer is cut short.
      if (hold_sync)
        d.st = bcs_pkg::st_hold;
      else
      begin
        take = 1'b1;
        d.req = req_valid_in ? req_in : bcs_pkg::IDLE_REQ;
        d.st = (d.req.kind == bcs_pkg::kind_halt) ? bcs_pkg::st_halt
                                                  : bcs_pkg::st_t1;
      end
    end
    d.pins = drive(d.st, d.req, q.pins);
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      q <= bcs_pkg::CORE_RESET;
    else
      q <= d;
  end

  assign req_ready_out = take;
  assign hold_ack_out = (q.st == bcs_pkg::st_hold);
  assign low_address_data_lines_out = q.pins.low_out;
  assign low_address_data_lines_oe_out = q.pins.low_oe;
  assign high_address_lines_out = q.pins.high_addr;
  assign high_address_lines_oe_out = q.pins.high_oe;
  assign io_select_out = q.pins.io_m;
  assign io_select_oe_out = q.pins.io_m_oe;
  assign cycle_status_1_out = q.pins.s1;
  assign cycle_status_0_out = q.pins.s0;
  assign read_strobe_n_out = q.pins.rd_n;
  assign write_strobe_n_out = q.pins.wr_n;
  assign read_write_oe_out = q.pins.rw_oe;
  assign interrupt_ack_strobe_n_out = q.pins.interrupt_ack_strobe_n_n;
  assign address_latch_out = q.pins.ale;
  assign read_data_out = q.rdata;
  assign cycle_done_out = q.done;

  chk_ale_first_state: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.pins.ale |-> q.st == bcs_pkg::st_t1 && !q.req.no_ale
                   && q.pins.low_oe ##1 !q.pins.ale)
    else $error("Address latch strobe outside first state.");

  chk_io_port_copy: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st == bcs_pkg::st_t1 && is_io(q.req.kind)
    |-> q.pins.high_addr == q.pins.low_out)
    else $error("Port address not copied on both bytes.");

  chk_write_encoding: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st == bcs_pkg::st_t1 && q.req.kind == bcs_pkg::kind_mem_wr
    |-> {q.pins.io_m, q.pins.s1, q.pins.s0} == 3'h1
        ##1 !q.pins.wr_n && q.pins.rd_n && q.pins.interrupt_ack_strobe_n_n)
    else $error("Memory write cycle encoded wrongly.");

  chk_status_held: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st == bcs_pkg::st_t1
    |-> q.pins.rd_n && q.pins.wr_n && q.pins.interrupt_ack_strobe_n_n
        ##1 $stable({q.pins.io_m, q.pins.s1, q.pins.s0}))
    else $error("Status not steady from first state or strobe early.");

  chk_idle_strobes: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st == bcs_pkg::st_t2 && q.req.kind == bcs_pkg::kind_idle_add
    |-> q.pins.rd_n && q.pins.wr_n && q.pins.interrupt_ack_strobe_n_n)
    else $error("Strobe asserted in a bus idle cycle.");

  chk_cycle_length: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st == bcs_pkg::st_t1 && q.req.kind == bcs_pkg::kind_mem_rd
    && ready_in ##1 ready_in
    |=> q.st == bcs_pkg::st_t3 ##1 q.st != bcs_pkg::st_t4)
    else $error("Memory cycle not three states long.");

  chk_late_states: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st inside {bcs_pkg::st_t4, bcs_pkg::st_t5, bcs_pkg::st_t6}
    |-> q.pins.s1 && q.pins.s0 && !q.pins.low_oe && q.pins.rd_n
        && q.pins.wr_n && q.pins.interrupt_ack_strobe_n_n
        && q.pins.io_m == (q.req.kind == bcs_pkg::kind_int_ack))
    else $error("Late fetch state drives wrong lines.");

  chk_wait_insert: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st inside {bcs_pkg::st_t2, bcs_pkg::st_wait} && !ready_in
    |=> q.st == bcs_pkg::st_wait && $stable(q.pins.rd_n))
    else $error("Wait state not inserted while ready low.");

  chk_hold_float: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st == bcs_pkg::st_hold
    |-> !q.pins.high_oe && !q.pins.low_oe && !q.pins.io_m_oe
        && !q.pins.rw_oe && hold_ack_out)
    else $error("Bus driven during hold.");

  chk_low_address: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    q.st == bcs_pkg::st_t1
    |-> q.pins.low_oe && q.pins.low_out == q.req.addr[7:0])
    else $error("Low address not driven in first state.");

  chk_hold_sync: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    hold_in ##1 hold_in |=> hold_sync)
    else $error("Hold not seen two edges after input.");

endmodule : bcs_sequencer

// ===== bcs_pkg.sv
package bcs_pkg;

  typedef enum logic [3:0] {
    st_t1,
    st_t2,
    st_wait,
    st_t3,
    st_t4,
    st_t5,
    st_t6,
    st_reset,
    st_halt,
    st_hold
  } bcs_state_type;

  typedef enum logic [3:0] {
    kind_fetch,
    kind_mem_rd,
    kind_mem_wr,
    kind_io_rd,
    kind_io_wr,
    kind_int_ack,
    kind_idle_add,
    kind_idle_rst,
    kind_halt
  } bcs_kind_type;

  // Status is {select, status 1, status 0}.
  localparam logic [2:0] STAT_FETCH = 3'h3;
  localparam logic [2:0] STAT_MEM_RD = 3'h2;
  localparam logic [2:0] STAT_MEM_WR = 3'h1;
  localparam logic [2:0] STAT_IO_RD = 3'h6;
  localparam logic [2:0] STAT_IO_WR = 3'h5;
  localparam logic [2:0] STAT_INT_ACK = 3'h7;
  localparam logic [2:0] STAT_IDLE_ADD = 3'h2;
  localparam logic [2:0] STAT_IDLE_RST = 3'h7;
  localparam logic [2:0] STAT_HALT = 3'h0;

  // Strobes are {read, write, acknowledge}, low when asserted.
  localparam logic [2:0] STRB_READ = 3'h3;
  localparam logic [2:0] STRB_WRITE = 3'h5;
  localparam logic [2:0] STRB_ACK = 3'h6;
  localparam logic [2:0] STRB_NONE = 3'h7;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    bcs_kind_type kind;
    logic long_fetch;
    logic no_ale;
  } bcs_req_type;

  typedef struct packed {
    logic io_m;
    logic io_m_oe;
    logic s1;
    logic s0;
    logic rd_n;
    logic wr_n;
    logic rw_oe;
    logic interrupt_ack_strobe_n_n;
    logic ale;
    logic [7:0] high_addr;
    logic high_oe;
    logic [7:0] low_out;
    logic low_oe;
  } bcs_pins_type;

  typedef struct packed {
    bcs_state_type st;
    bcs_req_type req;
    bcs_pins_type pins;
    logic [7:0] rdata;
    logic done;
  } bcs_core_type;

  typedef struct packed {
    logic first;
    logic second;
  } bcs_sync_type;

  localparam bcs_req_type IDLE_REQ = '{16'h0000, 8'h00, kind_idle_add,
                                       1'b0, 1'b1};
  localparam bcs_pins_type PINS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
                                          1'b1, 1'b0, 1'b1, 1'b0, 8'h00,
                                          1'b0, 8'h00, 1'b0};
  localparam bcs_core_type CORE_RESET = '{st_reset, IDLE_REQ, PINS_RESET,
                                          8'h00, 1'b0};
  localparam bcs_sync_type SYNC_RESET = '{1'b0, 1'b0};

endpackage : bcs_pkg

// ===== bcs_sync.sv
module bcs_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic level_in,
  output logic level_out
);

  bcs_pkg::bcs_sync_type q;
  bcs_pkg::bcs_sync_type d;

  // Only the second stage is visible, so metastability never leaks out.
  always_comb
  begin
    d.first = level_in;
    d.second = q.first;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      q <= bcs_pkg::SYNC_RESET;
    else
      q <= d;
  end

  assign level_out = q.second;

endmodule : bcs_sync

// ===== bcs_mem_model.sv
module bcs_mem_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ale_in,
  input wire logic [7:0] low_in,
  input wire logic low_oe_in,
  input wire logic [7:0] high_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic rw_oe_in,
  input wire logic ack_n_in,
  input wire logic slow_in,
  input wire logic stall_in,
  output logic ready_out,
  output logic [7:0] data_out,
  output logic [15:0] wr_addr_out,
  output logic [7:0] wr_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lat_q;
  logic ale_q;
  logic [7:0] last_q;
  logic drive;
  // Read and acknowledge strobes both make the far side answer.
  assign drive = (rw_oe_in && !rd_n_in) || !ack_n_in;
  // Released lines show the inverse of the last value, never a stale copy.
  assign data_out = drive ? (lat_q ^ high_in ^ 8'h5A) : ~last_q;
  // The forced wait comes from a flop fed by the latch strobe.
  assign ready_out = !stall_in && !(slow_in && ale_q);
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      lat_q <= 8'h00;
      ale_q <= 1'b0;
      last_q <= 8'h00;
      wr_addr_out <= 16'h0000;
      wr_data_out <= 8'h00;
    end
    else
    begin
      if (ale_in)
      begin
        lat_q <= low_in;
      end
      ale_q <= ale_in;
      last_q <= data_out;
      if (rw_oe_in && !wr_n_in && low_oe_in)
      begin
        wr_addr_out <= {high_in, lat_q};
        wr_data_out <= low_in;
      end
    end
  end
endmodule : bcs_mem_model

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, hold = 1'b0;
  logic slow = 1'b0, stall = 1'b0, rdy, ack, ale, req_rdy;
  bcs_pkg::bcs_req_type req = bcs_pkg::IDLE_REQ;
  logic [7:0] din, lo, hi, rdat, wdat, r = 8'h52;
  logic lo_oe, hi_oe, io, io_oe, s1, s0, rd_n, wr_n, rw_oe, ia_n, done;
  logic [15:0] wadr;
  int mismatches = 0, total_checks = 0;
  logic halted = 1'b0;
  bcs_sequencer i_bcs_sequencer (.clk_in(clk), .reset_n_in(rst_n),
    .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_rdy),
    .ready_in(rdy), .hold_in(hold), .hold_ack_out(ack),
    .low_address_data_lines_in(din), .low_address_data_lines_out(lo),
    .low_address_data_lines_oe_out(lo_oe), .high_address_lines_out(hi),
    .high_address_lines_oe_out(hi_oe), .io_select_out(io),
    .io_select_oe_out(io_oe), .cycle_status_1_out(s1),
    .cycle_status_0_out(s0), .read_strobe_n_out(rd_n),
    .write_strobe_n_out(wr_n), .read_write_oe_out(rw_oe),
    .interrupt_ack_strobe_n_out(ia_n), .address_latch_out(ale),
    .read_data_out(rdat), .cycle_done_out(done));
  bcs_mem_model i_bcs_mem_model (.clk_in(clk), .reset_n_in(rst_n),
    .ale_in(ale), .low_in(lo), .low_oe_in(lo_oe), .high_in(hi),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .rw_oe_in(rw_oe), .ack_n_in(ia_n),
    .slow_in(slow), .stall_in(stall), .ready_out(rdy), .data_out(din),
    .wr_addr_out(wadr), .wr_data_out(wdat));
  initial
  begin
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic [2:0] exp_stat(input bcs_pkg::bcs_kind_type k);
    case (k)
      bcs_pkg::kind_fetch: return bcs_pkg::STAT_FETCH;
      bcs_pkg::kind_mem_rd: return bcs_pkg::STAT_MEM_RD;
      bcs_pkg::kind_mem_wr: return bcs_pkg::STAT_MEM_WR;
      bcs_pkg::kind_io_rd: return bcs_pkg::STAT_IO_RD;
      bcs_pkg::kind_io_wr: return bcs_pkg::STAT_IO_WR;
      bcs_pkg::kind_int_ack: return bcs_pkg::STAT_INT_ACK;
      bcs_pkg::kind_idle_add: return bcs_pkg::STAT_IDLE_ADD;
      bcs_pkg::kind_idle_rst: return bcs_pkg::STAT_IDLE_RST;
      default: return bcs_pkg::STAT_HALT;
    endcase
  endfunction : exp_stat
  function automatic logic [2:0] exp_strb(input bcs_pkg::bcs_kind_type k);
    case (k)
      bcs_pkg::kind_fetch, bcs_pkg::kind_mem_rd,
      bcs_pkg::kind_io_rd: return bcs_pkg::STRB_READ;
      bcs_pkg::kind_mem_wr, bcs_pkg::kind_io_wr: return bcs_pkg::STRB_WRITE;
      bcs_pkg::kind_int_ack: return bcs_pkg::STRB_ACK;
      default: return bcs_pkg::STRB_NONE;
    endcase
  endfunction : exp_strb
  task automatic check(input string name, input logic [23:0] seen,
                       input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic run_cycle(input bcs_pkg::bcs_kind_type k,
    input logic [15:0] a, input logic [7:0] wd, input logic lng,
    input logic na, input int w, input logic sl);
    int n;
    int en;
    logic p;
    logic f;
    logic [5:0] lt;
    logic [7:0] h;
    p = (k == bcs_pkg::kind_io_rd) || (k == bcs_pkg::kind_io_wr);
    f = (k == bcs_pkg::kind_fetch) || (k == bcs_pkg::kind_int_ack);
    lt = {2'h3, (k == bcs_pkg::kind_int_ack), 3'h3};
    h = p ? a[7:0] : a[15:8];
    n = 0;
    repeat (50) if (req_rdy !== 1'b1 && !halted) @(negedge clk);
    if (!halted) check("ready", req_rdy, 1'b1);
    halted = 1'b0;
    req_valid = 1'b1;
    req = '{a, wd, k, lng, na};
    slow = sl;
    en = 3 + ((w > 0) ? w : int'(sl));
    if (f) en += lng ? 3 : 1;
    @(negedge clk);
    req_valid = 1'b0;
    repeat (40)
    begin
      n++;
      stall = (n >= 2) && (n <= w + 1);
      if (k == bcs_pkg::kind_halt)
      begin
        check("halt", {s1, s0, io_oe, rw_oe, hi_oe}, 5'h00);
        @(negedge clk);
        check("halt2", {s1, s0, io_oe, rw_oe, hi_oe}, 5'h00);
        halted = 1'b1;
        return;
      end
      if (n == 1)
      begin
        check("ale", ale, !na);
        check("stat", {io, s1, s0}, exp_stat(k));
        check("strb1", {rd_n, wr_n, ia_n}, bcs_pkg::STRB_NONE);
        if (k < bcs_pkg::kind_int_ack)
          check("addr", {hi, lo}, {h, a[7:0]});
      end
      if (n == 2)
      begin
        check("ale2", ale, 1'b0);
        check("done2", done, 1'b0);
        check("strb2", {rd_n, wr_n, ia_n}, exp_strb(k));
        check("stat2", {io, s1, s0}, exp_stat(k));
        if (exp_strb(k) == bcs_pkg::STRB_WRITE)
          check("wdata", {lo_oe, lo}, {1'b1, wd});
      end
      if (f && n > en - (lng ? 3 : 1))
        check("late", {s1, s0, io, lo_oe, rd_n, ia_n}, lt);
      if (f && n == en - (lng ? 2 : 0))
        check("done", done, 1'b1);
      if (req_rdy === 1'b1) break;
      @(negedge clk);
    end
    check("length", 24'(n), 24'(en));
    @(negedge clk);
    if (!f) check("done", done, 1'b1);
    if (exp_strb(k) == bcs_pkg::STRB_READ || k == bcs_pkg::kind_int_ack)
      check("rdata", rdat, a[7:0] ^ h ^ 8'h5A);
    if (exp_strb(k) == bcs_pkg::STRB_WRITE)
      check("write", {wadr, wdat}, {h, a[7:0], wd});
  endtask : run_cycle
  task automatic hold_test();
    hold = 1'b1;
    @(negedge clk);
    check("sync", ack, 1'b0);
    repeat (20) if (ack !== 1'b1) @(negedge clk);
    check("hold", {ack, lo_oe, hi_oe, io_oe, rw_oe, ia_n}, 6'h21);
    hold = 1'b0;
    repeat (4) @(negedge clk);
    check("unhold", ack, 1'b0);
  endtask : hold_test
  initial
  begin
    #2000000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      r = lfsr(r);
      run_cycle(bcs_pkg::bcs_kind_type'(i), {r, ~r}, r ^ 8'h3C, 0, 0, 0, 0);
    end
    run_cycle(bcs_pkg::kind_fetch, 16'hFF00, 8'h00, 1, 0, 2, 0);
    run_cycle(bcs_pkg::kind_mem_rd, 16'h00FF, 8'h00, 0, 0, 0, 1);
    // The upper half of memory stands for memory-mapped peripherals.
    run_cycle(bcs_pkg::kind_mem_wr, 16'h8001, 8'hA5, 0, 0, 3, 0);
    run_cycle(bcs_pkg::kind_idle_add, 16'h0000, 8'h00, 0, 1, 0, 0);
    run_cycle(bcs_pkg::kind_idle_rst, 16'h0000, 8'h00, 0, 1, 0, 0);
    run_cycle(bcs_pkg::kind_halt, 16'h0000, 8'h00, 0, 0, 0, 0);
    run_cycle(bcs_pkg::kind_io_rd, 16'h1234, 8'h00, 0, 0, 1, 1);
    hold_test();
    repeat (12)
    begin
      r = lfsr(r);
      run_cycle(bcs_pkg::bcs_kind_type'(r % 5), {r, lfsr(r)}, ~r, r[5],
                0, int'(r[1:0]), r[2]);
    end
    stop_test();
  end
endmodule : testbench
